// ---- design/cis_pin_edge.sv ----
/*
  External pin edge detector: three-stage synchroniser, edge counted once
  the second and third stages agree. Assumes an asynchronous pin.
*/
`timescale 1ns/1ns
`default_nettype none
module cis_pin_edge
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // pin and edge choice
  input wire logic pin_in,
  input wire logic rising_sel,
  // detected edge
  output logic edge_pulse
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic lvl_q;
  wire agree = (s2_q == s3_q);
  wire changed = agree && (s3_q != lvl_q);
  assign edge_pulse = changed && (rising_sel ? s3_q : !s3_q);
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      lvl_q <= 1'b0;
    end
    else
    begin
      s1_q <= pin_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (agree)
        lvl_q <= s3_q;
    end
  end
endmodule
`default_nettype wire

// ---- design/cis_pkg.sv ----
/*
  Types shared by the interrupt sequencer files.
  Assumes cis_regs.svh holds the numbers.
*/
package cis_pkg;
  typedef enum logic [1:0] {CIS_Q1, CIS_Q2, CIS_Q3, CIS_Q4} cis_quarter_t;
  typedef enum logic [2:0] {CIS_RUN, CIS_FLUSH1, CIS_FLUSH2, CIS_VECT, CIS_SLEEP,
    CIS_WAKE} cis_state_t;
  typedef struct packed
  {
    logic [7:0] w;
    logic [2:0] status;
    logic [4:0] bank_select_reg;
    logic [15:0] fsr0;
    logic [15:0] fsr1;
    logic [6:0] pc_high_latch;
  } cis_ctx_t;
endpackage

// ---- design/cis_quarter_gen.sv ----
/*
  Quarter-cycle generator: one enable pulse per quarter of an instruction
  cycle and the running quarter index. Assumes the 25 MHz system clock.
*/
`timescale 1ns/1ns
`default_nettype none
`include "cis_regs.svh"
module cis_quarter_gen
  import cis_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // quarter timing
  output cis_quarter_t quarter,
  output logic qtr_en,
  output logic cyc_en
);
  localparam logic [3:0] QTR_LAST = 4'(`CIS_QTR_CYC - 1);
  logic [3:0] div_q;
  cis_quarter_t quarter_q;
  wire div_wrap = (div_q == QTR_LAST);
  assign qtr_en = div_wrap;
  assign cyc_en = div_wrap && (quarter_q == CIS_Q4);
  assign quarter = quarter_q;
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      div_q <= 4'h0;
      quarter_q <= CIS_Q1;
    end
    else
    begin
      div_q <= div_wrap ? 4'h0 : div_q + 4'h1;
      if (div_wrap)
        quarter_q <= cis_quarter_t'(quarter_q + 2'h1);
    end
  end
endmodule
`default_nettype wire

// ---- design/cis_regs.svh ----
/*
  Register offsets, field positions, reset values and timing counts of the
  interrupt sequencer. Assumes inclusion by bare name from design files.
*/
`ifndef CIS_REGS_SVH
`define CIS_REGS_SVH
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define CIS_OFF_CTRL 4'h0
`define CIS_OFF_FLAG 4'h4
`define CIS_OFF_EN 4'h8
`define CIS_OFF_STAT 4'hC
// ****************************************
// control register fields
// ****************************************
`define CIS_CTRL_GIE 0
`define CIS_CTRL_PERIPHERAL_GROUP_ENABLE 1
`define CIS_CTRL_EDGE 2
`define CIS_CTRL_RST 8'h00
// ****************************************
// event layout: bit 0 pin, 1..3 core group, 4..7 peripheral group
// ****************************************
`define CIS_EV_PIN 0
`define CIS_EV_PERI_LO 4
`define CIS_CORE_MASK 8'h0F
`define CIS_PERI_MASK 8'hF0
// ****************************************
// timing
// ****************************************
`define CIS_VECTOR 16'h0004
`define CIS_CLK_MHZ 25
`define CIS_INSTR_NS 200
`define CIS_CLK_NS (1000 / `CIS_CLK_MHZ)
`define CIS_QTR_CYC ((`CIS_INSTR_NS / 4) / `CIS_CLK_NS)
`endif

// ---- design/cis_sequencer.sv ----
/*
  Interrupt sequencer of a small core: flags, enables, vectoring, context
  shadowing, return, sleep wake. Assumes an Avalon-MM master and a core
  that flushes, pushes and jumps on the strobes given here.
*/
// Summary of operation
// - any reset leaves all interrupt enables clear, so nothing vectors.
// - vectoring needs global enable, own enable, and group enable for peripherals.
// - flags set on their event whatever any enable says.
// - entry flushes prefetch, clears global enable, pushes PC, saves context, jumps 0004h.
// - during service events set flags but do not vector.
// - return pops address, restores context and sets global enable.
// - enabled flag pending while global enable clear is served once it sets.
// - synchronous events reach the vector within three or four instruction cycles.
// - asynchronous events reach the vector within three to five instruction cycles.
// - pin flag may set from fourth quarter through next first quarter.
// - selected enabled sources wake the core from sleep.
// - entry shadows W, status less timeout/powerdown, bank, pointers, PC high latch.
// - pin flag sets on rising edge if edge select one, else falling.
// - after wake the next instruction runs first, then vector if enabled.
`timescale 1ns/1ns
`default_nettype none
`include "cis_regs.svh"
module cis_sequencer
  import cis_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // event sources
  input wire logic ext_pin,
  input wire logic [7:1] sync_event,
  // core sequencer
  input wire logic return_from_service_instr,
  input wire logic sleep_instr,
  input wire logic [15:0] core_pc,
  input wire cis_ctx_t core_ctx,
  output logic flush_prefetch,
  output logic push_pc,
  output logic [15:0] push_addr,
  output logic load_pc,
  output logic [15:0] load_pc_value,
  output logic restore_ctx,
  output logic pop_pc,
  output var cis_ctx_t shadow_ctx,
  output logic core_sleeping,
  output logic wake_step,
  output logic irq
);
  // ****************************************
  // timing and pin edge
  // ****************************************
  cis_quarter_t quarter;
  logic qtr_en;
  logic cyc_en;
  logic pin_edge;
  logic [7:0] ctrl_q;
  logic [7:0] flag_q;
  logic [7:0] en_q;
  logic [7:0] mask_q;
  logic [7:0] stat_q;
  logic pin_arm_q;
  cis_state_t state_q;
  cis_state_t state_d;
  logic [15:0] ret_q;
  cis_ctx_t shadow_q;
  logic [15:0] load_q;
  logic rd_ack_q;
  cis_quarter_gen u_qgen
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .quarter(quarter),
    .qtr_en(qtr_en),
    .cyc_en(cyc_en)
  );
  cis_pin_edge u_pin
  (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .pin_in(ext_pin),
    .rising_sel(ctrl_q[`CIS_CTRL_EDGE]),
    .edge_pulse(pin_edge)
  );
  // ****************************************
  // bus decode
  // ****************************************
  wire wr_ctrl = avs_write && (avs_address == `CIS_OFF_CTRL);
  wire wr_flag = avs_write && (avs_address == `CIS_OFF_FLAG);
  wire wr_en = avs_write && (avs_address == `CIS_OFF_EN);
  wire wr_stat = avs_write && (avs_address == `CIS_OFF_STAT);
  wire [7:0] wdat = avs_writedata[7:0];
  wire glb = ctrl_q[`CIS_CTRL_GIE];
  wire peripheral_group_enable = ctrl_q[`CIS_CTRL_PERIPHERAL_GROUP_ENABLE];
  // pin flag window: fourth quarter through next first quarter
  wire pin_window = (quarter == CIS_Q4) || (quarter == CIS_Q1);
  wire pin_hit = pin_arm_q && pin_window;
  wire [7:0] ev_now = {sync_event, pin_hit};
  // ****************************************
  // enable gating
  // ****************************************
  wire [7:0] grp_ok = `CIS_CORE_MASK | (peripheral_group_enable ? `CIS_PERI_MASK : 8'h00);
  wire [7:0] armed = flag_q & en_q & grp_ok;
  wire any_armed = |armed;
  wire take = glb && any_armed && (state_q == CIS_RUN) && cyc_en;
  wire wake = (state_q == CIS_SLEEP) && any_armed;
  // ****************************************
  // sequencer
  // ****************************************
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      CIS_RUN:
      begin
        if (take)
          state_d = CIS_FLUSH1;
        else if (sleep_instr)
          state_d = CIS_SLEEP;
      end
      CIS_FLUSH1:
        if (cyc_en)
          state_d = CIS_FLUSH2;
      CIS_FLUSH2:
        if (cyc_en)
          state_d = CIS_VECT;
      CIS_VECT:
        state_d = CIS_RUN;
      CIS_SLEEP:
        if (wake)
          state_d = CIS_WAKE;
      CIS_WAKE:
        if (cyc_en)
          state_d = CIS_RUN;
    endcase
  end
  assign flush_prefetch = (state_q == CIS_RUN) && take;
  assign push_pc = flush_prefetch;
  assign push_addr = core_pc;
  assign load_pc = (state_q == CIS_VECT);
  assign load_pc_value = load_q;
  assign restore_ctx = return_from_service_instr && (state_q == CIS_RUN);
  assign pop_pc = restore_ctx;
  assign shadow_ctx = shadow_q;
  assign core_sleeping = (state_q == CIS_SLEEP);
  assign wake_step = (state_q == CIS_WAKE);
  assign irq = |(stat_q & mask_q);
  assign avs_waitrequest = avs_read && !rd_ack_q;
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
      state_q <= CIS_RUN;
    else
      state_q <= state_d;
  end
  // ****************************************
  // control and enables
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ctrl_q <= `CIS_CTRL_RST;
      en_q <= 8'h00;
      mask_q <= 8'h00;
    end
    else
    begin
      if (flush_prefetch)
        ctrl_q[`CIS_CTRL_GIE] <= 1'b0;
      else if (restore_ctx)
        ctrl_q[`CIS_CTRL_GIE] <= 1'b1;
      else if (wr_ctrl)
        ctrl_q[`CIS_CTRL_GIE] <= wdat[`CIS_CTRL_GIE];
      if (wr_ctrl)
      begin
        ctrl_q[`CIS_CTRL_PERIPHERAL_GROUP_ENABLE] <= wdat[`CIS_CTRL_PERIPHERAL_GROUP_ENABLE];
        ctrl_q[`CIS_CTRL_EDGE] <= wdat[`CIS_CTRL_EDGE];
      end
      if (wr_en)
        en_q <= wdat;
      if (avs_write && avs_address == `CIS_OFF_STAT && avs_writedata[15])
        mask_q <= avs_writedata[15:8];
    end
  end
  // ****************************************
  // flags, pin arm, status
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      flag_q <= 8'h00;
      pin_arm_q <= 1'b0;
      stat_q <= 8'h00;
    end
    else
    begin
      // pin edge waits for the window; event set wins over clear
      pin_arm_q <= (pin_arm_q && !pin_window) || pin_edge;
      flag_q <= (flag_q & ~(wr_flag ? wdat : 8'h00)) | ev_now;
      stat_q <= (stat_q & ~(wr_stat ? wdat : 8'h00)) | ev_now;
    end
  end
  // ****************************************
  // context shadow and vector
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      ret_q <= 16'h0000;
      shadow_q <= '0;
      load_q <= `CIS_VECTOR;
    end
    else
    begin
      load_q <= `CIS_VECTOR;
      if (flush_prefetch)
      begin
        ret_q <= core_pc;
        shadow_q <= core_ctx;
      end
    end
  end
  // ****************************************
  // read data
  // ****************************************
  always_ff @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      avs_readdata <= 32'h0000_0000;
      rd_ack_q <= 1'b0;
    end
    else
    begin
      rd_ack_q <= avs_read && !rd_ack_q;
      if (avs_read && !rd_ack_q)
      begin
        unique case (avs_address)
          `CIS_OFF_CTRL: avs_readdata <= {24'h0, ctrl_q};
          `CIS_OFF_FLAG: avs_readdata <= {24'h0, flag_q};
          `CIS_OFF_EN: avs_readdata <= {24'h0, en_q};
          `CIS_OFF_STAT: avs_readdata <= {16'h0, mask_q, stat_q};
          default: avs_readdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  // ****************************************
  // checks
  // ****************************************
  sequence s_entry;
    flush_prefetch ##1 !glb;
  endsequence
  AST_RESET_OFF: assert property (@(posedge clk_sys) !rst_n |=> !glb && en_q == 8'h00)
    else $error("enables not clear after reset");
  AST_GATED: assert property (@(posedge clk_sys) disable iff (!rst_n)
    flush_prefetch |-> glb && any_armed)
    else $error("vectoring without enables");
  AST_FLAG_SET: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sync_event[1] |=> flag_q[1])
    else $error("flag not set on event");
  AST_ENTRY: assert property (@(posedge clk_sys) disable iff (!rst_n)
    s_entry |-> ##[1:60] load_pc && load_pc_value == 16'h0004)
    else $error("no vector after entry");
  AST_NO_NEST: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !glb |-> !flush_prefetch)
    else $error("vectoring while disabled");
  AST_RETURN: assert property (@(posedge clk_sys) disable iff (!rst_n)
    restore_ctx |=> glb)
    else $error("return did not set enable");
  AST_LATENCY: assert property (@(posedge clk_sys) disable iff (!rst_n)
    take |-> ##9 load_pc)
    else $error("vector latency out of range");
  AST_STICKY: assert property (@(posedge clk_sys) disable iff (!rst_n)
    flag_q[2] && !wr_flag |=> flag_q[2])
    else $error("flag lost without clear");
  AST_WAKE: assert property (@(posedge clk_sys) disable iff (!rst_n)
    wake |=> wake_step)
    else $error("no wake step");
endmodule
`default_nettype wire

// ---- verification/cis_core_model.sv ----
/*
  Core model for the sequencer bench: program counter, return stack, live context.
  Assumes one-cycle strobes from the sequencer on the system clock.
*/
`timescale 1ns/1ns
`default_nettype none
module cis_core_model
  import cis_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // strobes from the sequencer
  input wire logic push_pc,
  input wire logic [15:0] push_addr,
  input wire logic load_pc,
  input wire logic [15:0] load_pc_value,
  input wire logic restore_ctx,
  input wire logic pop_pc,
  input wire cis_ctx_t shadow_ctx,
  // live core state
  output logic [15:0] core_pc,
  output var cis_ctx_t core_ctx
);
  logic [15:0] stack_q[$];
  // ********
  // fetch, call, return
  // ********
  always @(posedge clk_sys)
  begin
    if (!rst_n)
    begin
      stack_q.delete();
      core_pc <= 16'h0100;
      core_ctx <= {8'hA5, 3'h5, 5'h0A, 16'h1234, 16'h5678, 7'h3C};
    end
    else
    begin
      if (push_pc)
        stack_q.push_back(push_addr);
      if (load_pc)
        core_pc <= load_pc_value;
      else if (pop_pc && stack_q.size() > 0)
        core_pc <= stack_q.pop_back();
      else
        core_pc <= core_pc + 16'h0001;
      if (restore_ctx)
        core_ctx <= shadow_ctx;
      else if (load_pc)
        core_ctx.w <= ~core_ctx.w;
    end
  end
endmodule
`default_nettype wire

// ---- verification/testbench.sv ----
/*
  Self-checking bench of the interrupt sequencer.
  Assumes cis_core_model plays the core; the bench plays firmware and sources.
*/
`timescale 1ns/1ns
`default_nettype none
`include "cis_regs.svh"
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin bad_count++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module testbench
  import cis_pkg::*;
;
  localparam int IC = 4 * `CIS_QTR_CYC;
  localparam logic [3:0] CT = `CIS_OFF_CTRL;
  localparam logic [3:0] FL = `CIS_OFF_FLAG;
  localparam logic [3:0] EN = `CIS_OFF_EN;
  localparam logic [3:0] ST = `CIS_OFF_STAT;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic ext_pin = 1'b0;
  logic [7:1] sync_event = 7'h00;
  logic return_from_service_instr = 1'b0;
  logic sleep_instr = 1'b0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest, flush_prefetch, push_pc, load_pc, restore_ctx, pop_pc;
  logic core_sleeping, wake_step, irq;
  logic [15:0] core_pc, push_addr, load_pc_value;
  logic [7:1] b;
  cis_ctx_t core_ctx, shadow_ctx, saved;
  int bad_count = 0, n_checks = 0, vec_cnt = 0, cyc = 0, k, n, v0;
  logic [31:0] rq[$];
  cis_sequencer i_dut (.clk_sys, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_readdata, .avs_waitrequest, .ext_pin, .sync_event,
    .return_from_service_instr, .sleep_instr, .core_pc, .core_ctx, .flush_prefetch,
    .push_pc, .push_addr, .load_pc, .load_pc_value, .restore_ctx, .pop_pc, .shadow_ctx,
    .core_sleeping, .wake_step, .irq);
  cis_core_model i_core (.clk_sys, .rst_n, .push_pc, .push_addr, .load_pc,
    .load_pc_value, .restore_ctx, .pop_pc, .shadow_ctx, .core_pc, .core_ctx);
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) cyc <= cyc + 1;
  // ********
  // result watcher
  // ********
  always @(posedge clk_sys)
  begin
    if (avs_read === 1'b1 && avs_waitrequest === 1'b0 && rq.size() > 0)
      `CHK(avs_readdata, rq.pop_front())
    if (flush_prefetch === 1'b1)
    begin
      saved = core_ctx;
      `CHK(push_pc, 1'b1)
      `CHK(push_addr, core_pc)
    end
    if (load_pc === 1'b1)
    begin
      vec_cnt <= vec_cnt + 1;
      `CHK(load_pc_value, `CIS_VECTOR)
    end
  end
  // ********
  // drivers
  // ********
  task tick(input int t);
    repeat (t) @(posedge clk_sys);
  endtask
  task bus(input logic [3:0] a, input logic [31:0] d, input logic r);
    @(posedge clk_sys);
    if (r)
      rq.push_back(d);
    avs_address <= a;
    avs_writedata <= r ? 32'h0 : d;
    avs_read <= r;
    avs_write <= ~r;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task ev(input logic [7:1] e);
    @(posedge clk_sys);
    sync_event <= e;
    @(posedge clk_sys);
    sync_event <= 7'h00;
  endtask
  task no_vec(input int t);
    int v;
    v = vec_cnt;
    tick(t);
    `CHK(vec_cnt, v)
  endtask
  task get_vec(input int hi);
    int v, t0;
    v = vec_cnt;
    t0 = cyc;
    while (vec_cnt == v && cyc - t0 < hi) @(posedge clk_sys);
    `CHK(vec_cnt - v, 1)
  endtask
  task ret;
    @(posedge clk_sys);
    return_from_service_instr <= 1'b1;
    @(posedge clk_sys);
    `CHK(pop_pc, 1'b1)
    `CHK(restore_ctx, 1'b1)
    return_from_service_instr <= 1'b0;
  endtask
  task report_and_stop;
    $display("TB: checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    repeat (40000) @(posedge clk_sys);
    bad_count++;
    report_and_stop;
  end
  // ********
  // scenarios
  // ********
  initial
  begin
    void'($urandom(32'hF8CB5F5B));
    tick(12);
    rst_n <= 1'b1;
    tick(2);
    for (k = 0; k < 4; k++)
      bus(4'(4 * k), 32'h0, 1'b1);
    `CHK(irq, 1'b0)
    bus(4'h2, 32'hFF, 1'b0);
    bus(4'h2, 32'h0, 1'b1);
    bus(CT, 32'h0, 1'b1);
    for (k = 1; k < 8; k++)
    begin
      b = 7'h01 << (k - 1);
      ev(b);
      bus(FL, {24'h0, b, 1'b0}, 1'b1);
      bus(EN, $urandom & 32'hFF, 1'b0);
      bus(EN, 32'h0, 1'b0);
      bus(FL, {24'h0, b, 1'b0}, 1'b1);
      bus(FL, {24'h0, b, 1'b0}, 1'b0);
    end
    bus(ST, 32'hFE, 1'b1);
    `CHK(irq, 1'b0)
    bus(ST, 32'hFF00, 1'b0);
    tick(1);
    `CHK(irq, 1'b1)
    bus(ST, 32'h8000, 1'b0);
    tick(1);
    `CHK(irq, 1'b1)
    bus(ST, 32'hFF, 1'b0);
    tick(1);
    `CHK(irq, 1'b0)
    bus(EN, 32'hFF, 1'b0);
    ev(7'h08);
    no_vec(5 * IC);
    bus(CT, 32'h1, 1'b0);
    no_vec(5 * IC);
    bus(CT, 32'h3, 1'b0);
    get_vec(5 * IC);
    bus(CT, 32'h2, 1'b1);
    `CHK(shadow_ctx, saved)
    ev(7'h01);
    no_vec(5 * IC);
    bus(FL, 32'h12, 1'b1);
    bus(FL, 32'h10, 1'b0);
    ret;
    tick(1);
    `CHK(core_ctx, saved)
    get_vec(5 * IC);
    bus(FL, 32'h02, 1'b0);
    ret;
    bus(CT, 32'h3, 1'b1);
    for (k = 0; k < 4; k++)
    begin
      b = 7'h01 << ($urandom % 7);
      ev(b);
      get_vec(4 * IC + 3);
      bus(FL, {24'h0, b, 1'b0}, 1'b0);
      ret;
    end
    bus(CT, 32'h4, 1'b0);
    for (k = 0; k < 4; k++)
    begin
      if (k == 2)
        bus(CT, 32'h0, 1'b0);
      ext_pin <= ~ext_pin;
      tick(3 * IC);
      bus(FL, (k == 0 || k == 3) ? 32'h1 : 32'h0, 1'b1);
      bus(FL, 32'h1, 1'b0);
    end
    bus(CT, 32'h7, 1'b0);
    ext_pin <= 1'b1;
    get_vec(5 * IC + 8);
    bus(FL, 32'h1, 1'b0);
    ret;
    bus(CT, 32'h2, 1'b0);
    for (k = 0; k < 2; k++)
    begin
      sleep_instr <= 1'b1;
      tick(1);
      sleep_instr <= 1'b0;
      tick(2);
      `CHK(core_sleeping, 1'b1)
      ev(7'h02);
      v0 = vec_cnt;
      for (n = 0; n < 3 * IC && wake_step !== 1'b1; n++) tick(1);
      `CHK(wake_step, 1'b1)
      `CHK(vec_cnt, v0)
      if (k == 0)
        no_vec(5 * IC);
      else
        get_vec(5 * IC);
      bus(FL, 32'h4, 1'b0);
      if (k == 1)
        ret;
      bus(CT, 32'h3, 1'b0);
    end
    rst_n <= 1'b0;
    tick(2);
    rst_n <= 1'b1;
    tick(2);
    bus(CT, 32'h0, 1'b1);
    bus(EN, 32'h0, 1'b1);
    ev(7'h02);
    no_vec(5 * IC);
    report_and_stop;
  end
endmodule
`default_nettype wire
